//--- core/ptg_top.sv
// two pulse output axes with trapezoidal profiles and two pwm outputs
//
// How it works
// R01 - two independent pulse axes per module
// R02 - cw/ccw pulses or pulse plus direction
// R03 - rate is 33.33 MHz divided by integer
// R04 - trapezoidal ramp, linear or s-shaped
// R05 - profile period selectable 1 or 4 ms
// R06 - profile commands act after 1 to 2 periods
// R07 - immediate stop: 10 us plus current pulse
// R08 - pwm frequency and duty ranges and steps
// R09 - pwm stop drops output at once
// R10 - position counts each pulse, signed by direction
`timescale 1ns/1ps
`include "ptg_defs.svh"
module ptg_top #(
  parameter int PER_SHORT_CYC = `PTG_PER_SHORT_US * `PTG_MCLK_MHZ,
  parameter int PER_LONG_CYC = `PTG_PER_LONG_US * `PTG_MCLK_MHZ
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic cfg_period_4ms_i,
  input wire logic [1:0] cfg_dir_mode_i,
  input wire logic [1:0] cfg_scurve_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_axis_i,
  input wire ptg_pkg::ptg_op_t cmd_op_i,
  input wire logic [31:0] cmd_target_i,
  input wire logic [16:0] cmd_speed_i,
  input wire logic [16:0] cmd_accel_i,
  input wire logic pwm_cmd_valid_i,
  input wire logic pwm_ch_i,
  input wire logic pwm_stop_i,
  input wire logic [15:0] pwm_freq_i,
  input wire logic pwm_freq_hz_i,
  input wire logic [9:0] pwm_duty_i,
  input wire logic pwm_duty_pct_i,
  output logic [1:0] pulse_a_o,
  output logic [1:0] pulse_b_o,
  output logic [1:0] busy_o,
  output logic [1:0][31:0] pos_o,
  output logic [1:0] pwm_o
);
  ptg_pkg::ptg_top_t s_q;
  ptg_pkg::ptg_top_t s_d;
  ptg_pwm_if pwm_if [2] ();

  function automatic logic [16:0] clamp_spd(input logic [16:0] v);
    if (v < `PTG_SPD_MIN) begin
      return `PTG_SPD_MIN;
    end
    return (v > `PTG_SPD_MAX) ? `PTG_SPD_MAX : v;
  endfunction : clamp_spd

  // integer divider of the reference, zero speed gives the longest period
  function automatic logic [31:0] ref_div(input logic [16:0] spd);
    if (spd == 17'h0) begin
      return 32'hffffffff;
    end
    return 32'(`PTG_REF_HZ) / 32'(spd); // R03
  endfunction : ref_div

  // decel distance cur^2 * T / (2000 * acc) against the remaining pulses
  function automatic logic brake(input logic [31:0] rem, input logic [16:0] cur, input logic [16:0] acc,
                                 input logic long_per);
    logic [63:0] lhs;
    logic [63:0] rhs;
    lhs = 64'(rem) * 64'(acc) * `PTG_BRAKE_K;
    rhs = 64'(cur) * 64'(cur) * (long_per ? `PTG_PER_LONG_MS : `PTG_PER_SHORT_MS);
    return lhs <= rhs;
  endfunction : brake

  // s-shape: step grows by a quarter of acc, halves near the target speed
  function automatic logic [16:0] ramp_step(input logic [16:0] step, input logic [16:0] acc,
                                            input logic [16:0] diff, input logic scurve);
    logic [16:0] inc;
    logic [17:0] grown;
    inc = (acc[16:2] == 15'h0) ? 17'h1 : {2'b00, acc[16:2]};
    grown = 18'(step) + 18'(inc);
    if (!scurve) begin
      return acc;
    end
    if (18'(diff) > 18'(step) * 18'h2) begin
      return (grown > 18'(acc)) ? acc : grown[16:0];
    end
    return (step[16:1] == 16'h0) ? 17'h1 : {1'b0, step[16:1]};
  endfunction : ramp_step

  logic [12:0] ref_sum;
  logic prof;
  logic [16:0] eff;
  logic [16:0] diff;
  logic [31:0] rem;
  ptg_pkg::ptg_cmd_t c;

  always_comb begin
    s_d = s_q;
    eff = '0;
    diff = '0;
    rem = '0;
    c = '0;
    ref_sum = 13'(s_q.ref_acc + `PTG_REF_INC);
    s_d.ref_tick = ref_sum >= `PTG_REF_MOD; // R03
    s_d.ref_acc = s_d.ref_tick ? 13'(ref_sum - `PTG_REF_MOD) : ref_sum;
    prof = s_q.tick_cnt >= 18'((cfg_period_4ms_i ? PER_LONG_CYC : PER_SHORT_CYC) - 1); // R05
    s_d.tick_cnt = prof ? 18'h0 : 18'(s_q.tick_cnt + 18'h1);
    for (int i = 0; i < 2; i++) begin // R01
      if (prof) begin
        c = s_q.ax[i].stg;
        // a command waits in pend up to the next period start, then one full period in stg, so it acts after 1 to 2 periods
        if (c.v && s_q.ax[i].st != ptg_pkg::PTG_HALT) begin // R06
          s_d.ax[i].stg.v = 1'b0;
          unique case (c.op)
            ptg_pkg::PTG_OP_DSTOP: begin
              s_d.ax[i].want = '0;
            end
            ptg_pkg::PTG_OP_SPEED: begin
              s_d.ax[i].want = clamp_spd(c.spd);
              s_d.ax[i].acc = clamp_spd(c.acc);
              s_d.ax[i].move = 1'b0;
              if (s_q.ax[i].st == ptg_pkg::PTG_IDLE) begin
                s_d.ax[i].dir = !c.tgt[31];
                s_d.ax[i].st = ptg_pkg::PTG_RUN;
                s_d.ax[i].cur = '0;
                s_d.ax[i].step = '0;
                s_d.ax[i].cnt = '0;
              end
            end
            ptg_pkg::PTG_OP_MOVE: begin
              // a target behind a running axis: decelerate to stop, then reapply
              if (s_q.ax[i].st == ptg_pkg::PTG_RUN &&
                  (($signed(c.tgt) > $signed(s_q.ax[i].pos)) != s_q.ax[i].dir)) begin
                s_d.ax[i].want = '0;
                s_d.ax[i].move = 1'b0;
                s_d.ax[i].stg.v = 1'b1;
              end else begin
                s_d.ax[i].tgt = c.tgt;
                s_d.ax[i].want = clamp_spd(c.spd);
                s_d.ax[i].acc = clamp_spd(c.acc);
                s_d.ax[i].move = 1'b1;
                if (s_q.ax[i].st == ptg_pkg::PTG_IDLE && c.tgt != s_q.ax[i].pos) begin
                  s_d.ax[i].dir = $signed(c.tgt) > $signed(s_q.ax[i].pos);
                  s_d.ax[i].st = ptg_pkg::PTG_RUN;
                  s_d.ax[i].cur = '0;
                  s_d.ax[i].step = '0;
                  s_d.ax[i].cnt = '0;
                end
              end
            end
            default: begin
            end
          endcase
        end
        if (s_q.ax[i].pend.v && !s_d.ax[i].stg.v) begin
          s_d.ax[i].stg = s_q.ax[i].pend; // R06
          s_d.ax[i].pend.v = 1'b0;
        end
        if (s_d.ax[i].st == ptg_pkg::PTG_RUN) begin
          eff = s_d.ax[i].want;
          rem = s_d.ax[i].dir ? 32'(s_d.ax[i].tgt - s_d.ax[i].pos) : 32'(s_d.ax[i].pos - s_d.ax[i].tgt);
          if (s_d.ax[i].move && eff != 17'h0 && brake(rem, s_d.ax[i].cur, s_d.ax[i].acc, cfg_period_4ms_i)) begin
            eff = `PTG_SPD_MIN;
          end
          diff = (s_d.ax[i].cur > eff) ? 17'(s_d.ax[i].cur - eff) : 17'(eff - s_d.ax[i].cur);
          s_d.ax[i].step = ramp_step(s_d.ax[i].step, s_d.ax[i].acc, diff, cfg_scurve_i[i]); // R04
          if (diff <= s_d.ax[i].step) begin
            s_d.ax[i].cur = eff; // R04
          end else if (s_d.ax[i].cur < eff) begin
            s_d.ax[i].cur = 17'(s_d.ax[i].cur + s_d.ax[i].step);
          end else begin
            s_d.ax[i].cur = 17'(s_d.ax[i].cur - s_d.ax[i].step);
          end
          if (s_d.ax[i].cur == 17'h0) begin
            s_d.ax[i].st = ptg_pkg::PTG_IDLE;
            s_d.ax[i].ph = 1'b0;
          end
          s_d.ax[i].div = ref_div(s_d.ax[i].cur); // R03
        end
      end
      if (cmd_valid_i && cmd_axis_i == 1'(i)) begin
        if (cmd_op_i == ptg_pkg::PTG_OP_ISTOP) begin
          if (s_q.ax[i].st != ptg_pkg::PTG_IDLE) begin
            s_d.ax[i].st = ptg_pkg::PTG_HALT; // R07
            s_d.ax[i].hold = 9'(`PTG_ISTOP_CYC);
          end
          s_d.ax[i].pend.v = 1'b0;
          s_d.ax[i].stg.v = 1'b0;
        end else if (cmd_op_i == ptg_pkg::PTG_OP_SETPOS) begin
          if (s_q.ax[i].st == ptg_pkg::PTG_IDLE) begin
            s_d.ax[i].pos = cmd_target_i;
          end
        end else begin
          s_d.ax[i].pend = '{v: 1'b1, op: cmd_op_i, tgt: cmd_target_i, spd: cmd_speed_i, acc: cmd_accel_i};
        end
      end
      if (s_q.ax[i].st == ptg_pkg::PTG_HALT && s_q.ax[i].hold != 9'h0) begin
        s_d.ax[i].hold = 9'(s_q.ax[i].hold - 9'h1); // R07
      end
      if (s_q.ref_tick && s_d.ax[i].st != ptg_pkg::PTG_IDLE && s_d.ax[i].cur != 17'h0) begin
        if (s_d.ax[i].cnt + 32'h1 >= s_d.ax[i].div) begin
          s_d.ax[i].cnt = '0;
          s_d.ax[i].ph = 1'b0;
          // the pulse in flight completes before a halt or move end stops the axis; only a new one is withheld
          if (s_d.ax[i].st == ptg_pkg::PTG_HALT && s_d.ax[i].hold == 9'h0) begin
            s_d.ax[i].st = ptg_pkg::PTG_IDLE; // R07
            s_d.ax[i].cur = '0;
          end else if (s_d.ax[i].move && s_d.ax[i].pos == s_d.ax[i].tgt) begin
            s_d.ax[i].st = ptg_pkg::PTG_IDLE;
            s_d.ax[i].cur = '0;
          end else begin
            s_d.ax[i].ph = 1'b1;
            s_d.ax[i].pos = s_d.ax[i].dir ? 32'(s_d.ax[i].pos + 32'h1) : 32'(s_d.ax[i].pos - 32'h1); // R10
          end
        end else begin
          s_d.ax[i].cnt = 32'(s_d.ax[i].cnt + 32'h1);
          if (s_d.ax[i].cnt >= {1'b0, s_d.ax[i].div[31:1]}) begin
            s_d.ax[i].ph = 1'b0;
          end
        end
      end
      if (cfg_dir_mode_i[i]) begin
        s_d.ax[i].a = s_d.ax[i].ph; // R02
        s_d.ax[i].b = s_d.ax[i].dir;
      end else begin
        s_d.ax[i].a = s_d.ax[i].ph & s_d.ax[i].dir; // R02
        s_d.ax[i].b = s_d.ax[i].ph & !s_d.ax[i].dir;
      end
      s_d.ax[i].busy = s_d.ax[i].st != ptg_pkg::PTG_IDLE;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign pulse_a_o[g] = s_q.ax[g].a;
    assign pulse_b_o[g] = s_q.ax[g].b;
    assign busy_o[g] = s_q.ax[g].busy;
    assign pos_o[g] = s_q.ax[g].pos;
    assign pwm_if[g].ref_tick = s_q.ref_tick;
    assign pwm_if[g].start = pwm_cmd_valid_i && pwm_ch_i == 1'(g) && !pwm_stop_i;
    assign pwm_if[g].stop = pwm_cmd_valid_i && pwm_ch_i == 1'(g) && pwm_stop_i;
    assign pwm_if[g].freq = pwm_freq_i;
    assign pwm_if[g].freq_hz = pwm_freq_hz_i;
    assign pwm_if[g].duty = pwm_duty_i;
    assign pwm_if[g].duty_pct = pwm_duty_pct_i;
    assign pwm_o[g] = pwm_if[g].out;
    ptg_pwm u_pwm (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .pif(pwm_if[g].gen)
    );
  end
endmodule : ptg_top

//--- core/ptg_defs.svh
// timing counts, limits and constants of the pulse train and pwm generator
`ifndef PTG_DEFS_SVH
`define PTG_DEFS_SVH
`define PTG_MCLK_MHZ 40
`define PTG_REF_HZ 33330000
`define PTG_REF_INC 13'h0d05
`define PTG_REF_MOD 13'h0fa0
`define PTG_SPD_MIN 17'h00001
`define PTG_SPD_MAX 17'h186a0
`define PTG_PER_SHORT_US 1000
`define PTG_PER_LONG_US 4000
`define PTG_PER_SHORT_MS 64'h1
`define PTG_PER_LONG_MS 64'h4
`define PTG_BRAKE_K 64'h7d0
`define PTG_ISTOP_NS 10000
`define PTG_ISTOP_CYC ((`PTG_ISTOP_NS * `PTG_MCLK_MHZ + 999) / 1000)
`define PTG_PWM_FMAX_HZ 16'h8020
`define PTG_PWM_DECI 64'ha
`define PTG_DUTY_FULL 64'h3e8
`endif

//--- core/ptg_pkg.sv
// types of the pulse train and pwm generator
package ptg_pkg;
  typedef enum logic [2:0] {PTG_OP_ISTOP, PTG_OP_DSTOP, PTG_OP_SPEED, PTG_OP_MOVE, PTG_OP_SETPOS} ptg_op_t;
  typedef enum logic [1:0] {PTG_IDLE, PTG_RUN, PTG_HALT} ptg_axst_t;
  typedef struct packed {
    logic v;
    ptg_op_t op;
    logic [31:0] tgt;
    logic [16:0] spd;
    logic [16:0] acc;
  } ptg_cmd_t;
  typedef struct packed {
    ptg_axst_t st;
    logic dir;
    logic move;
    logic [31:0] pos;
    logic [31:0] tgt;
    logic [16:0] cur;
    logic [16:0] want;
    logic [16:0] acc;
    logic [16:0] step;
    logic [31:0] div;
    logic [31:0] cnt;
    logic ph;
    logic [8:0] hold;
    ptg_cmd_t pend;
    ptg_cmd_t stg;
    logic a;
    logic b;
    logic busy;
  } ptg_axis_t;
  typedef struct packed {
    logic [12:0] ref_acc;
    logic ref_tick;
    logic [17:0] tick_cnt;
    ptg_axis_t [1:0] ax;
  } ptg_top_t;
  typedef struct packed {
    logic run;
    logic [31:0] per;
    logic [31:0] hi;
    logic [31:0] cnt;
    logic out;
  } ptg_pwm_t;
endpackage : ptg_pkg

//--- core/ptg_pwm_if.sv
// control and output signals between the axis core and one pwm channel
`timescale 1ns/1ps
interface ptg_pwm_if;
  logic ref_tick;
  logic start;
  logic stop;
  logic [15:0] freq;
  logic freq_hz;
  logic [9:0] duty;
  logic duty_pct;
  logic out;
  modport ctl (output ref_tick, start, stop, freq, freq_hz, duty, duty_pct, input out);
  modport gen (input ref_tick, start, stop, freq, freq_hz, duty, duty_pct, output out);
endinterface : ptg_pwm_if

//--- core/ptg_pwm.sv
// one pwm channel counting reference ticks
`timescale 1ns/1ps
`include "ptg_defs.svh"
module ptg_pwm (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  ptg_pwm_if.gen pif
);
  ptg_pkg::ptg_pwm_t s_q;
  ptg_pkg::ptg_pwm_t s_d;
  logic [63:0] num;
  logic [63:0] den;
  logic [63:0] per;
  logic [63:0] duty;

  always_comb begin
    s_d = s_q;
    num = pif.freq_hz ? 64'(`PTG_REF_HZ) : 64'(`PTG_REF_HZ) * `PTG_PWM_DECI;
    den = (pif.freq == 16'h0000) ? 64'h1 : 64'(pif.freq);
    if (pif.freq_hz && pif.freq > `PTG_PWM_FMAX_HZ) begin
      den = 64'(`PTG_PWM_FMAX_HZ);
    end
    per = num / den; // R08
    duty = pif.duty_pct ? 64'(pif.duty) * `PTG_PWM_DECI : 64'(pif.duty);
    if (duty > `PTG_DUTY_FULL) begin
      duty = `PTG_DUTY_FULL;
    end
    if (pif.ref_tick && s_q.run) begin
      s_d.cnt = (s_q.cnt + 32'h1 >= s_q.per) ? 32'h0 : s_q.cnt + 32'h1;
    end
    if (pif.start) begin
      s_d.run = 1'b1;
      s_d.per = per[31:0];
      s_d.hi = 32'((per * duty) / `PTG_DUTY_FULL); // R08
      if (!s_q.run || s_d.cnt >= per[31:0]) begin
        s_d.cnt = 32'h0;
      end
    end
    // no wait for the period end: the line drops on the next edge
    if (pif.stop) begin
      s_d.run = 1'b0; // R09
      s_d.cnt = 32'h0;
    end
    s_d.out = s_d.run && (s_d.cnt < s_d.hi); // R09
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pif.out = s_q.out;
endmodule : ptg_pwm

//--- testbench/ptg_top_asserts.sv
// port assertions of the pulse train and pwm generator
`timescale 1ns/1ps
module ptg_top_asserts (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] cfg_dir_mode_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_axis_i,
  input wire ptg_pkg::ptg_op_t cmd_op_i,
  input wire logic pwm_cmd_valid_i,
  input wire logic pwm_ch_i,
  input wire logic pwm_stop_i,
  input wire logic [1:0] pulse_a_o,
  input wire logic [1:0] pulse_b_o,
  input wire logic [1:0] busy_o,
  input wire logic [1:0][31:0] pos_o,
  input wire logic [1:0] pwm_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire cmd0 = cmd_valid_i && !cmd_axis_i;
  a_cw_ccw_apart: assert property (!cfg_dir_mode_i[0] |-> !(pulse_a_o[0] && pulse_b_o[0]))
    else $error("cw and ccw high together");
  a_dir_steady: assert property (cfg_dir_mode_i[1] && pulse_a_o[1] |-> $stable(pulse_b_o[1]))
    else $error("direction moved during a pulse");
  a_pulse_needs_busy: assert property ($rose(pulse_a_o[0]) |-> busy_o[0])
    else $error("pulse on an idle axis");
  a_cw_counts_up: assert property (!cfg_dir_mode_i[0] && $rose(pulse_a_o[0])
    |-> pos_o[0] == $past(pos_o[0]) + 32'h1)
    else $error("cw pulse did not add one");
  a_idle_pos_still: assert property (!busy_o[0] && !cmd0 |=> $stable(pos_o[0]))
    else $error("position moved on an idle axis");
  a_speed_window: assert property (cmd0 && cmd_op_i == ptg_pkg::PTG_OP_SPEED && !busy_o[0]
    |=> (!busy_o[0]) [*8] ##[1:330] busy_o[0])
    else $error("speed command outside its window");
  a_istop_holds: assert property (cmd0 && cmd_op_i == ptg_pkg::PTG_OP_ISTOP && busy_o[0] |-> ##300 busy_o[0])
    else $error("immediate stop ended early");
  a_pwm0_stop: assert property (pwm_cmd_valid_i && pwm_stop_i && !pwm_ch_i |=> !pwm_o[0])
    else $error("pwm 0 kept running after stop");
  a_pwm1_stop: assert property (pwm_cmd_valid_i && pwm_stop_i && pwm_ch_i |=> !pwm_o[1])
    else $error("pwm 1 kept running after stop");
endmodule : ptg_top_asserts
bind ptg_top ptg_top_asserts i_asserts (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cfg_dir_mode_i(cfg_dir_mode_i),
  .cmd_valid_i(cmd_valid_i), .cmd_axis_i(cmd_axis_i), .cmd_op_i(cmd_op_i), .pwm_cmd_valid_i(pwm_cmd_valid_i),
  .pwm_ch_i(pwm_ch_i), .pwm_stop_i(pwm_stop_i), .pulse_a_o(pulse_a_o), .pulse_b_o(pulse_b_o),
  .busy_o(busy_o), .pos_o(pos_o), .pwm_o(pwm_o));

//--- testbench/ptg_drive_model.sv
// motor drive model counting steps seen on the pulse lines
`timescale 1ns/1ps
module ptg_drive_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] dir_mode_i,
  input wire logic [1:0] pulse_a_i,
  input wire logic [1:0] pulse_b_i,
  output logic [1:0][31:0] steps_o
);
  logic [1:0] a_q;
  logic [1:0] b_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_q <= 2'h0;
      b_q <= 2'h0;
      steps_o <= '0;
    end else begin
      a_q <= pulse_a_i;
      b_q <= pulse_b_i;
      for (int i = 0; i < 2; i++) begin
        // direction level is read at the step edge, as a real drive latches it
        if (dir_mode_i[i] && pulse_a_i[i] && !a_q[i]) begin
          steps_o[i] <= pulse_b_i[i] ? steps_o[i] + 32'h1 : steps_o[i] - 32'h1;
        end else if (!dir_mode_i[i] && pulse_a_i[i] && !a_q[i]) begin
          steps_o[i] <= steps_o[i] + 32'h1;
        end else if (!dir_mode_i[i] && pulse_b_i[i] && !b_q[i]) begin
          steps_o[i] <= steps_o[i] - 32'h1;
        end
      end
    end
  end
endmodule : ptg_drive_model

//--- testbench/test_ptg_top.sv
// self-checking bench of the pulse train and pwm generator
`timescale 1ns/1ps
module test_ptg_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cfg_period_4ms_i = 1'b0;
  logic [1:0] cfg_dir_mode_i = 2'h2;
  logic [1:0] cfg_scurve_i = 2'h2;
  logic cmd_valid_i = 1'b0;
  logic cmd_axis_i = 1'b0;
  ptg_pkg::ptg_op_t cmd_op_i = ptg_pkg::PTG_OP_ISTOP;
  logic [31:0] cmd_target_i = 32'h0;
  logic [16:0] cmd_speed_i = 17'h0;
  logic [16:0] cmd_accel_i = 17'h186a0;
  logic pwm_cmd_valid_i = 1'b0;
  logic pwm_ch_i = 1'b0;
  logic pwm_stop_i = 1'b0;
  logic [15:0] pwm_freq_i = 16'h0;
  logic pwm_freq_hz_i = 1'b0;
  logic [9:0] pwm_duty_i = 10'h0;
  logic pwm_duty_pct_i = 1'b0;
  logic [1:0] pulse_a_o, pulse_b_o, busy_o, pwm_o;
  logic [1:0][31:0] pos_o;
  logic [1:0][31:0] steps;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 mclk_i = ~mclk_i;
  // short profile periods keep the run brief
  ptg_top #(.PER_SHORT_CYC(40), .PER_LONG_CYC(160)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cfg_period_4ms_i(cfg_period_4ms_i), .cfg_dir_mode_i(cfg_dir_mode_i), .cfg_scurve_i(cfg_scurve_i),
    .cmd_valid_i(cmd_valid_i), .cmd_axis_i(cmd_axis_i), .cmd_op_i(cmd_op_i), .cmd_target_i(cmd_target_i),
    .cmd_speed_i(cmd_speed_i), .cmd_accel_i(cmd_accel_i), .pwm_cmd_valid_i(pwm_cmd_valid_i),
    .pwm_ch_i(pwm_ch_i), .pwm_stop_i(pwm_stop_i), .pwm_freq_i(pwm_freq_i), .pwm_freq_hz_i(pwm_freq_hz_i),
    .pwm_duty_i(pwm_duty_i), .pwm_duty_pct_i(pwm_duty_pct_i), .pulse_a_o(pulse_a_o),
    .pulse_b_o(pulse_b_o), .busy_o(busy_o), .pos_o(pos_o), .pwm_o(pwm_o));
  ptg_drive_model i_drive (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .dir_mode_i(cfg_dir_mode_i),
    .pulse_a_i(pulse_a_o), .pulse_b_i(pulse_b_o), .steps_o(steps));
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic cmd(input logic ax, input ptg_pkg::ptg_op_t op, input logic [31:0] tgt, input logic [16:0] spd);
    @(negedge mclk_i);
    cmd_valid_i = 1'b1;
    cmd_axis_i = ax;
    cmd_op_i = op;
    cmd_target_i = tgt;
    cmd_speed_i = spd;
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
  endtask : cmd
  task automatic pwm(input logic ch, input logic stp, input logic [15:0] f, input logic hz, input logic [9:0] d);
    @(negedge mclk_i);
    pwm_cmd_valid_i = 1'b1;
    pwm_ch_i = ch;
    pwm_stop_i = stp;
    pwm_freq_i = f;
    pwm_freq_hz_i = hz;
    pwm_duty_i = d;
    pwm_duty_pct_i = hz;
    @(negedge mclk_i);
    pwm_cmd_valid_i = 1'b0;
    @(negedge mclk_i);
  endtask : pwm
  task automatic wait_idle(input logic ax);
    for (int i = 0; i < 20000 && busy_o[ax] !== 1'b0; i++) @(negedge mclk_i);
  endtask : wait_idle
  task automatic t_setpos();
    check(busy_o === 2'h0 && pwm_o === 2'h0 && pos_o[0] === 32'h0, "outputs not clear after reset");
    cmd(1'b0, ptg_pkg::PTG_OP_SETPOS, 32'h100, 17'h0);
    @(negedge mclk_i);
    check(pos_o[0] === 32'h100, "position not loaded");
    $display("test setpos done");
  endtask : t_setpos
  task automatic t_cw_istop();
    logic [31:0] p;
    cmd(1'b0, ptg_pkg::PTG_OP_SPEED, 32'h0, 17'h186a0);
    repeat (3000) @(negedge mclk_i);
    check(busy_o[0] === 1'b1 && steps[0] !== 32'h0, "axis 0 not pulsing");
    cmd(1'b0, ptg_pkg::PTG_OP_ISTOP, 32'h0, 17'h0);
    wait_idle(1'b0);
    check(busy_o[0] === 1'b0, "axis 0 never went idle");
    p = pos_o[0];
    check(p - 32'h100 === steps[0], "position and drive steps differ");
    repeat (800) @(negedge mclk_i);
    check(pos_o[0] === p && p - 32'h100 === steps[0], "pulses after stop");
    $display("test cw istop done");
  endtask : t_cw_istop
  // only the start of a move is watched: the final crawl at the lowest rate outlasts any run
  task automatic t_move();
    logic [31:0] p;
    logic [31:0] s;
    p = pos_o[0];
    s = steps[0];
    cmd(1'b0, ptg_pkg::PTG_OP_MOVE, 32'(p + 32'h1000), 17'h186a0);
    repeat (3000) @(negedge mclk_i);
    check(busy_o[0] === 1'b1 && pulse_b_o[0] === 1'b0 && pos_o[0] - p != 32'h0, "move not running forward");
    cmd(1'b0, ptg_pkg::PTG_OP_ISTOP, 32'h0, 17'h0);
    wait_idle(1'b0);
    check(busy_o[0] === 1'b0 && pos_o[0] - p === steps[0] - s, "move count and drive steps differ");
    check(pos_o[0] - p < 32'h1000, "move passed its target");
    $display("test move done");
  endtask : t_move
  task automatic t_rev_dstop();
    cfg_period_4ms_i = 1'b1;
    cmd(1'b1, ptg_pkg::PTG_OP_SPEED, 32'h80000000, 17'h0c350);
    repeat (150) @(negedge mclk_i);
    check(busy_o[1] === 1'b0, "axis 1 started inside one period");
    repeat (175) @(negedge mclk_i);
    check(busy_o[1] === 1'b1, "axis 1 not started within two long periods");
    repeat (2675) @(negedge mclk_i);
    check(busy_o[1] === 1'b1 && steps[1][31] === 1'b1, "axis 1 not reversing");
    check(pulse_b_o[1] === 1'b0, "direction level not reverse");
    cmd(1'b1, ptg_pkg::PTG_OP_DSTOP, 32'h0, 17'h0);
    repeat (150) @(negedge mclk_i);
    check(busy_o[1] === 1'b1, "stop acted inside one period");
    wait_idle(1'b1);
    check(busy_o[1] === 1'b0 && pos_o[1] === steps[1], "axis 1 count wrong after stop");
    cfg_period_4ms_i = 1'b0;
    $display("test reverse dstop done");
  endtask : t_rev_dstop
  task automatic t_pwm();
    pwm(1'b0, 1'b0, 16'h2710, 1'b0, 10'h1f4);
    check(pwm_o[0] === 1'b1, "pwm 0 not high at start");
    repeat (19000) @(negedge mclk_i);
    check(pwm_o[0] === 1'b1, "pwm 0 high phase short");
    repeat (2000) @(negedge mclk_i);
    check(pwm_o[0] === 1'b0, "pwm 0 high phase long");
    repeat (20000) @(negedge mclk_i);
    check(pwm_o[0] === 1'b1, "pwm 0 period wrong");
    pwm(1'b0, 1'b1, 16'h0, 1'b0, 10'h0);
    check(pwm_o[0] === 1'b0, "pwm 0 not stopped");
    pwm(1'b1, 1'b0, 16'h8020, 1'b1, 10'h019);
    repeat (200) @(negedge mclk_i);
    check(pwm_o[1] === 1'b1, "pwm 1 high phase short");
    repeat (250) @(negedge mclk_i);
    check(pwm_o[1] === 1'b0, "pwm 1 high phase long");
    repeat (850) @(negedge mclk_i);
    check(pwm_o[1] === 1'b1, "pwm 1 period wrong");
    pwm(1'b1, 1'b1, 16'h0, 1'b1, 10'h0);
    check(pwm_o[1] === 1'b0, "pwm 1 not stopped mid pulse");
    $display("test pwm done");
  endtask : t_pwm
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      $display("MISMATCH at %0t: run timed out", $time);
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1'b1;
    @(negedge mclk_i);
    t_setpos();
    t_cw_istop();
    t_move();
    t_rev_dstop();
    t_pwm();
    give_verdict();
  end
endmodule : test_ptg_top
